/* File: hdl/pts_pkg.sv */
// Constants and register map of the PPS time synchronisation unit
package pts_pkg;
  // Clock and timing
  localparam longint CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam longint BAUD_BPS = 9600;
  localparam int BIT_CYC = int'((CLK_HZ + BAUD_BPS / 2) / BAUD_BPS);
  localparam longint PPS_MIN_US = 10;
  localparam int PPS_MIN_CYC = int'((PPS_MIN_US * CLK_HZ + 999_999)
    / 1_000_000);
  localparam longint PPS_MAX_MS = 200;
  localparam int PPS_MAX_CYC = int'(PPS_MAX_MS * CLK_HZ / 1000);
  localparam longint PPS_PERIOD_MS = 1000;
  localparam longint PPS_TOL_US = 100;
  localparam int PER_MIN_CYC = int'(PPS_PERIOD_MS * CLK_HZ / 1000
    - PPS_TOL_US * CLK_HZ / 1_000_000);
  localparam int PER_MAX_CYC = int'(PPS_PERIOD_MS * CLK_HZ / 1000
    + PPS_TOL_US * CLK_HZ / 1_000_000);
  localparam longint RMC_LATE_MS = 500;
  localparam int RMC_LATE_CYC = int'(RMC_LATE_MS * CLK_HZ / 1000);
  localparam int CNT_W = 28;
  localparam logic [1:0] GOOD_PERIODS = 2'h2;
  // Timestamp
  localparam logic [31:0] NS_MAX = 32'h3b9ac9ff;
  localparam logic [31:0] NS_STEP = 32'(CLK_PERIOD_NS);
  localparam logic [47:0] TS_ORIGIN_SEC = 48'h0;
  localparam logic [31:0] DAYS_TO_2000 = 32'h2acd;
  localparam logic [47:0] SEC_PER_DAY = 48'h15180;
  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PHASE = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] REG_TS_NS = 8'h14;
  localparam logic [7:0] REG_TS_SEC_LO = 8'h18;
  localparam logic [7:0] REG_TS_SEC_HI = 8'h1c;
  localparam logic [7:0] REG_PTP_NS = 8'h20;
  localparam logic [7:0] REG_PTP_SEC_LO = 8'h24;
  localparam logic [7:0] REG_PTP_SEC_HI = 8'h28;
  localparam logic [7:0] REG_PTP_CMD = 8'h2c;
  // Fields and reset values
  localparam int CTRL_SRC_PTP = 0;
  localparam int CTRL_PL_EN = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [15:0] PHASE_RST = 16'h0000;
  localparam int IRQ_W = 5;
  localparam int IRQ_PPS = 0;
  localparam int IRQ_RMC_OK = 1;
  localparam int IRQ_LOADED = 2;
  localparam int IRQ_PPS_FAULT = 3;
  localparam int IRQ_NMEA_ERR = 4;
  localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;
  // Characters
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_STAR = 8'h2a;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [23:0] RMC_TAG = 24'h524d43;
  localparam logic [3:0] FLD_TIME = 4'h1;
  localparam logic [3:0] FLD_VALID = 4'h2;
  localparam logic [3:0] FLD_DATE = 4'h9;
  localparam logic [3:0] FLD_MODE = 4'hc;
  // State machines
  typedef enum logic [3:0] {
    U_IDLE = 4'b0001, U_START = 4'b0010, U_DATA = 4'b0100, U_STOP = 4'b1000
  } pts_uart_e;
  typedef enum logic [3:0] {
    P_IDLE = 4'b0001, P_BODY = 4'b0010, P_CK1 = 4'b0100, P_CK2 = 4'b1000
  } pts_parse_e;
endpackage

/* File: hdl/pts_time_sync.sv */
// PPS / NMEA / PTP disciplined seconds-plus-nanoseconds timestamp unit
`timescale 1ns/10ps
// Behaviour
// - Source is GPS+PPS or PTP, by config
// - PPS active high, rising edge references time
// - Serial fixed at 9600 baud 8N1
// - Only RMC used; fields 1,2,9,12; checksum
// - Time applied only when mode is A
// - Fields found by commas, any length
// - PTP mode is slave only
// - Source lost: keep counting, power-up resets
// - Unsynchronised count starts at default origin
// - Seconds since 1970 plus nanoseconds
// - Nanoseconds wrap past 0x3B9AC9FF, seconds increment
// - Phase lock drives rotor azimuth at PPS
// - Phase lock only with stable PPS
module pts_time_sync import pts_pkg::*; #(
  parameter int BIT_CYCLES = BIT_CYC,
  parameter int PPS_MAX_CYCLES = PPS_MAX_CYC,
  parameter int PER_MIN_CYCLES = PER_MIN_CYC,
  parameter int PER_MAX_CYCLES = PER_MAX_CYC,
  parameter int RMC_LATE_CYCLES = RMC_LATE_CYC
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // GPS link
  input wire logic gps_serial_receive,
  input wire logic pps_input,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Timestamp for the main stream packet
  output logic [47:0] ts_sec,
  output logic [31:0] ts_ns,
  output logic ts_synced,
  output logic pps_locked,
  // Rotor phase lock
  output logic rotor_lock_strobe,
  output logic [15:0] rotor_lock_azimuth,
  // Interrupt
  output logic irq
);

  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] hexval(input logic [7:0] c);
    logic [7:0] u;
    u = c & 8'hdf;
    if (c <= 8'h39) begin
      return c[3:0];
    end
    return 4'(u - 8'h37);
  endfunction

  function automatic logic [31:0] d2(input logic [3:0] a,
    input logic [3:0] b);
    return 32'(a) * 32'h0a + 32'(b);
  endfunction

  function automatic logic [31:0] month_days(input logic [31:0] mo);
    case (mo)
      32'h2: return 32'd31;
      32'h3: return 32'd59;
      32'h4: return 32'd90;
      32'h5: return 32'd120;
      32'h6: return 32'd151;
      32'h7: return 32'd181;
      32'h8: return 32'd212;
      32'h9: return 32'd243;
      32'ha: return 32'd273;
      32'hb: return 32'd304;
      32'hc: return 32'd334;
      default: return 32'd0;
    endcase
  endfunction

  // Years are taken as 20yy; valid through 2099
  function automatic logic [47:0] epoch(input logic [5:0][3:0] t,
    input logic [5:0][3:0] d);
    logic [31:0] yy, mo, days, tod;
    yy = d2(d[4], d[5]);
    mo = d2(d[2], d[3]);
    days = DAYS_TO_2000 + yy * 32'd365 + (yy + 32'h3) / 32'h4
      + month_days(mo) + d2(d[0], d[1]) - 32'h1;
    if (yy[1:0] == 2'h0 && mo > 32'h2) begin
      days = days + 32'h1;
    end
    tod = d2(t[0], t[1]) * 32'd3600 + d2(t[2], t[3]) * 32'd60
      + d2(t[4], t[5]);
    return 48'(days) * SEC_PER_DAY + 48'(tod);
  endfunction

  // Serial receiver, fixed 8N1
  pts_uart_e us, next_us;
  logic [13:0] ucnt, next_ucnt;
  logic [2:0] ubit, next_ubit;
  logic [7:0] ushift, next_ushift;
  logic rx_valid, frame_err;

  always_comb begin
    next_us = us;
    next_ucnt = ucnt - 14'h1;
    next_ubit = ubit;
    next_ushift = ushift;
    rx_valid = 1'b0;
    frame_err = 1'b0;
    unique case (us)
      U_IDLE: begin
        next_ucnt = 14'(BIT_CYCLES / 2);
        if (!gps_serial_receive) begin
          next_us = U_START;
        end
      end
      U_START: if (ucnt == 14'h0) begin
        next_ucnt = 14'(BIT_CYCLES - 1);
        next_ubit = 3'h0;
        next_us = gps_serial_receive ? U_IDLE : U_DATA;
      end
      U_DATA: if (ucnt == 14'h0) begin
        next_ucnt = 14'(BIT_CYCLES - 1);
        next_ushift = {gps_serial_receive, ushift[7:1]};
        next_ubit = ubit + 3'h1;
        if (ubit == 3'h7) begin
          next_us = U_STOP;
        end
      end
      U_STOP: if (ucnt == 14'h0) begin
        rx_valid = gps_serial_receive;
        frame_err = !gps_serial_receive;
        next_us = U_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      us <= U_IDLE;
      ucnt <= 14'h0;
      ubit <= 3'h0;
      ushift <= 8'h00;
    end else if (ce) begin
      us <= next_us;
      ucnt <= next_ucnt;
      ubit <= next_ubit;
      ushift <= next_ushift;
    end
  end

  // Sentence parser
  pts_parse_e ps, next_ps;
  logic [3:0] fld, next_fld;
  logic [2:0] idx, next_idx;
  logic [7:0] xsum, next_xsum, valid_ch, next_valid_ch, mode_ch,
    next_mode_ch;
  logic [3:0] ck_hi, next_ck_hi;
  logic hdr_ok, next_hdr_ok;
  logic [5:0][3:0] tdig, next_tdig, ddig, next_ddig;
  logic rmc_ok, cksum_err;

  always_comb begin
    next_ps = ps;
    next_fld = fld;
    next_idx = idx;
    next_xsum = xsum;
    next_valid_ch = valid_ch;
    next_mode_ch = mode_ch;
    next_ck_hi = ck_hi;
    next_hdr_ok = hdr_ok;
    next_tdig = tdig;
    next_ddig = ddig;
    rmc_ok = 1'b0;
    cksum_err = 1'b0;
    if (rx_valid && ushift == CH_DOLLAR) begin
      next_ps = P_BODY;
      next_fld = 4'h0;
      next_idx = 3'h0;
      next_xsum = 8'h00;
      next_valid_ch = 8'h00;
      next_mode_ch = 8'h00;
      next_hdr_ok = 1'b1;
    end else if (rx_valid) begin
      unique case (ps)
        P_IDLE: ;
        P_BODY: begin
          if (ushift == CH_STAR) begin
            next_ps = P_CK1;
          end else if (ushift < 8'h20) begin
            next_ps = P_IDLE;
          end else begin
            next_xsum = xsum ^ ushift;
            if (idx != 3'h7) begin
              next_idx = idx + 3'h1;
            end
            if (ushift == CH_COMMA) begin
              next_idx = 3'h0;
              if (fld != 4'hf) begin
                next_fld = fld + 4'h1;
              end
              if (fld == 4'h0 && idx != 3'h5) begin
                next_hdr_ok = 1'b0;
              end
            end else if (fld == 4'h0 && idx >= 3'h2) begin
              if (idx > 3'h4 ||
                ushift != RMC_TAG[8*(3'h4-idx) +: 8]) begin
                next_hdr_ok = 1'b0;
              end
            end else if (fld == FLD_TIME && idx < 3'h6) begin
              next_tdig[idx] = ushift[3:0];
            end else if (fld == FLD_DATE && idx < 3'h6) begin
              next_ddig[idx] = ushift[3:0];
            end else if (fld == FLD_VALID && idx == 3'h0) begin
              next_valid_ch = ushift;
            end else if (fld == FLD_MODE && idx == 3'h0) begin
              next_mode_ch = ushift;
            end
          end
        end
        P_CK1: begin
          next_ck_hi = hexval(ushift);
          next_ps = P_CK2;
        end
        P_CK2: begin
          next_ps = P_IDLE;
          if ({ck_hi, hexval(ushift)} != xsum) begin
            cksum_err = 1'b1;
          end else if (hdr_ok && valid_ch == CH_A
            && mode_ch == CH_A) begin
            rmc_ok = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ps <= P_IDLE;
      fld <= 4'h0;
      idx <= 3'h0;
      xsum <= 8'h00;
      valid_ch <= 8'h00;
      mode_ch <= 8'h00;
      ck_hi <= 4'h0;
      hdr_ok <= 1'b0;
      tdig <= '0;
      ddig <= '0;
    end else if (ce) begin
      ps <= next_ps;
      fld <= next_fld;
      idx <= next_idx;
      xsum <= next_xsum;
      valid_ch <= next_valid_ch;
      mode_ch <= next_mode_ch;
      ck_hi <= next_ck_hi;
      hdr_ok <= next_hdr_ok;
      tdig <= next_tdig;
      ddig <= next_ddig;
    end
  end

  // PPS watch, timestamp and phase lock
  logic [1:0] ctrl;
  logic [15:0] phase;
  logic ptp_load;
  logic [31:0] ptp_ns;
  logic [47:0] ptp_sec;
  logic pps_q, next_pps_q, locked, next_locked, synced, next_synced;
  logic [CNT_W-1:0] hi_cnt, next_hi_cnt, per_cnt, next_per_cnt;
  logic [1:0] good, next_good;
  logic pend, next_pend, pl_stb, next_pl_stb;
  logic [47:0] pend_sec, next_pend_sec, sec, next_sec;
  logic [31:0] ns, next_ns;
  logic pps_rise, pps_fault, loaded, rmc_late;

  always_comb begin
    next_pps_q = pps_input;
    pps_rise = pps_input && !pps_q;
    pps_fault = 1'b0;
    loaded = 1'b0;
    next_locked = locked;
    next_good = good;
    next_hi_cnt = pps_input ? hi_cnt + CNT_W'(1) : '0;
    next_per_cnt = per_cnt;
    if (per_cnt <= CNT_W'(PER_MAX_CYCLES)) begin
      next_per_cnt = per_cnt + CNT_W'(1);
    end else begin
      next_locked = 1'b0;
      next_good = 2'h0;
    end
    if (hi_cnt == CNT_W'(PPS_MAX_CYCLES + 1)) begin
      pps_fault = 1'b1;
    end
    if (!pps_input && pps_q && hi_cnt < CNT_W'(PPS_MIN_CYC)) begin
      pps_fault = 1'b1;
    end
    if (pps_rise) begin
      next_per_cnt = '0;
      if (per_cnt >= CNT_W'(PER_MIN_CYCLES)
        && per_cnt <= CNT_W'(PER_MAX_CYCLES)) begin
        if (good != GOOD_PERIODS) begin
          next_good = good + 2'h1;
        end else begin
          next_locked = 1'b1;
        end
      end else begin
        next_good = 2'h0;
        next_locked = 1'b0;
      end
    end
    // Sentences after the deadline are not paired with any pulse
    rmc_late = per_cnt > CNT_W'(RMC_LATE_CYCLES);
    next_pend = pend && !pps_rise;
    next_pend_sec = pend_sec;
    if (rmc_ok && !rmc_late) begin
      next_pend = 1'b1;
      next_pend_sec = epoch(tdig, ddig) + 48'h1;
    end
    // A pulse that breaks the lock must not move the rotor
    next_pl_stb = pps_rise && locked && next_locked
      && ctrl[CTRL_PL_EN];
    next_synced = synced;
    if (ns >= NS_MAX - NS_STEP + 32'h1) begin
      next_ns = 32'h0;
      next_sec = sec + 48'h1;
    end else begin
      next_ns = ns + NS_STEP;
      next_sec = sec;
    end
    if (!ctrl[CTRL_SRC_PTP] && pps_rise && pend) begin
      next_sec = pend_sec;
      next_ns = 32'h0;
      next_synced = 1'b1;
      loaded = 1'b1;
    end else if (ctrl[CTRL_SRC_PTP] && ptp_load) begin
      next_sec = ptp_sec;
      next_ns = ptp_ns;
      next_synced = 1'b1;
      loaded = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pps_q <= 1'b0;
      locked <= 1'b0;
      good <= 2'h0;
      hi_cnt <= '0;
      per_cnt <= '1;
      pend <= 1'b0;
      pend_sec <= 48'h0;
      pl_stb <= 1'b0;
      synced <= 1'b0;
      sec <= TS_ORIGIN_SEC;
      ns <= 32'h0;
    end else if (ce) begin
      pps_q <= next_pps_q;
      locked <= next_locked;
      good <= next_good;
      hi_cnt <= next_hi_cnt;
      per_cnt <= next_per_cnt;
      pend <= next_pend;
      pend_sec <= next_pend_sec;
      pl_stb <= next_pl_stb;
      synced <= next_synced;
      sec <= next_sec;
      ns <= next_ns;
    end
  end

  // Register file on the Wishbone slave
  logic [1:0] next_ctrl;
  logic [15:0] next_phase;
  logic [IRQ_W-1:0] istat, next_istat, imask, next_imask, events;
  logic [31:0] next_ptp_ns, next_dat, wv;
  logic [47:0] next_ptp_sec, snap, next_snap;
  logic next_ack, wr, rd;

  always_comb begin
    wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
    next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_ctrl = ctrl;
    next_phase = phase;
    next_imask = imask;
    next_ptp_ns = ptp_ns;
    next_ptp_sec = ptp_sec;
    next_snap = snap;
    next_dat = wb_dat_o;
    ptp_load = 1'b0;
    events = '0;
    events[IRQ_PPS] = pps_rise;
    events[IRQ_RMC_OK] = rmc_ok && !rmc_late;
    events[IRQ_LOADED] = loaded;
    events[IRQ_PPS_FAULT] = pps_fault;
    events[IRQ_NMEA_ERR] = cksum_err || frame_err || (rmc_ok && rmc_late);
    wv = 32'h0;
    if (wr) begin
      unique case (wb_adr_i)
        REG_CTRL: begin
          wv = merge({30'h0, ctrl}, wb_dat_i, wb_sel_i);
          next_ctrl = wv[1:0];
        end
        REG_PHASE: begin
          wv = merge({16'h0, phase}, wb_dat_i, wb_sel_i);
          next_phase = wv[15:0];
        end
        REG_IRQ_STAT: wv = merge(32'h0, wb_dat_i, wb_sel_i);
        REG_IRQ_MASK: begin
          wv = merge({27'h0, imask}, wb_dat_i, wb_sel_i);
          next_imask = wv[IRQ_W-1:0];
        end
        REG_PTP_NS: next_ptp_ns = merge(ptp_ns, wb_dat_i, wb_sel_i);
        REG_PTP_SEC_LO: next_ptp_sec[31:0] =
          merge(ptp_sec[31:0], wb_dat_i, wb_sel_i);
        REG_PTP_SEC_HI: begin
          wv = merge({16'h0, ptp_sec[47:32]}, wb_dat_i, wb_sel_i);
          next_ptp_sec[47:32] = wv[15:0];
        end
        REG_PTP_CMD: ptp_load = wb_sel_i[0] && wb_dat_i[0];
        default: ;
      endcase
    end
    // Set beats clear in the same cycle
    next_istat = (istat & ~((wr && wb_adr_i == REG_IRQ_STAT) ?
      wv[IRQ_W-1:0] : '0)) | events;
    if (rd) begin
      unique case (wb_adr_i)
        REG_CTRL: next_dat = {30'h0, ctrl};
        REG_PHASE: next_dat = {16'h0, phase};
        REG_STATUS: next_dat = {28'h0, pend, ctrl[CTRL_SRC_PTP],
          locked, synced};
        REG_IRQ_STAT: next_dat = {27'h0, istat};
        REG_IRQ_MASK: next_dat = {27'h0, imask};
        REG_TS_NS: begin
          next_dat = ns;
          next_snap = sec; // seconds frozen with the ns read
        end
        REG_TS_SEC_LO: next_dat = snap[31:0];
        REG_TS_SEC_HI: next_dat = {16'h0, snap[47:32]};
        REG_PTP_NS: next_dat = ptp_ns;
        REG_PTP_SEC_LO: next_dat = ptp_sec[31:0];
        REG_PTP_SEC_HI: next_dat = {16'h0, ptp_sec[47:32]};
        default: next_dat = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl <= CTRL_RST;
      phase <= PHASE_RST;
      istat <= IRQ_RST;
      imask <= IRQ_RST;
      ptp_ns <= 32'h0;
      ptp_sec <= 48'h0;
      snap <= 48'h0;
      wb_dat_o <= 32'h0;
      wb_ack_o <= 1'b0;
    end else if (ce) begin
      ctrl <= next_ctrl;
      phase <= next_phase;
      istat <= next_istat;
      imask <= next_imask;
      ptp_ns <= next_ptp_ns;
      ptp_sec <= next_ptp_sec;
      snap <= next_snap;
      wb_dat_o <= next_dat;
      wb_ack_o <= next_ack;
    end
  end

  assign ts_sec = sec;
  assign ts_ns = ns;
  assign ts_synced = synced;
  assign pps_locked = locked;
  assign rotor_lock_strobe = pl_stb;
  assign rotor_lock_azimuth = phase;
  assign irq = |(istat & imask);

endmodule

/* File: test/pts_time_sync_checker.sv */
// Port-level assertions for the PPS time synchronisation unit
`timescale 1ns/10ps
module pts_time_sync_checker (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Watched inputs
  input wire logic pps_input,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  // Watched outputs
  input wire logic wb_ack_o,
  input wire logic [47:0] ts_sec,
  input wire logic [31:0] ts_ns,
  input wire logic ts_synced,
  input wire logic pps_locked,
  input wire logic rotor_lock_strobe
);
  localparam logic [31:0] NS_TOP = 32'd999999990;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  logic quiet;
  // Enabled edge on which no load can land
  assign quiet = ce && !pps_input && !(wb_cyc_i && wb_stb_i);

  ack_answer_a: assert property (ce && wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("request not acked next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  ns_step_a: assert property (quiet && ts_ns < NS_TOP
    |=> ts_ns == $past(ts_ns) + 32'd10 && $stable(ts_sec))
    else $error("nanosecond step wrong");
  ns_wrap_a: assert property (quiet && ts_ns >= NS_TOP
    |=> ts_ns == 32'h0 && ts_sec == $past(ts_sec) + 48'h1)
    else $error("nanosecond wrap wrong");
  strobe_pulse_a: assert property (rotor_lock_strobe
    |=> !rotor_lock_strobe) else $error("strobe longer than one cycle");
  strobe_rise_a: assert property (rotor_lock_strobe
    |-> pps_locked && $past(pps_input) && !$past(pps_input, 2))
    else $error("strobe not tied to a locked pulse rise");
  synced_hold_a: assert property (ts_synced |=> ts_synced)
    else $error("synced flag dropped");

  cover property (wb_ack_o);
  cover property (rotor_lock_strobe);
  cover property ($rose(ts_synced));
  cover property (quiet && ts_ns >= NS_TOP ##1 ts_ns == 32'h0);
endmodule

bind pts_time_sync pts_time_sync_checker u_pts_time_sync_checker (
  .clk(clk), .srst(srst), .ce(ce), .pps_input(pps_input),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .ts_sec(ts_sec), .ts_ns(ts_ns), .ts_synced(ts_synced),
  .pps_locked(pps_locked), .rotor_lock_strobe(rotor_lock_strobe));

/* File: test/pts_gps_model.sv */
// GPS receiver model: pulse per second plus NMEA sentences
`timescale 1ns/10ps
module pts_gps_model #(
  parameter int BIT = 16,
  parameter int WIDTH = 1100,
  parameter int PERIOD = 10000
) (
  // Clock
  input wire logic clk,
  // GPS link
  output logic pps_input,
  output logic gps_serial_receive
);
  int cyc = 0;
  int t0 = 0;
  initial begin
    pps_input = 1'b0;
    gps_serial_receive = 1'b1;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task automatic pulse_start();
    @(posedge clk);
    pps_input <= 1'b1;
    t0 = cyc;
  endtask

  // Start bit, LSB first, stop bit leaves the line idle high
  task automatic send_byte(input logic [7:0] b);
    for (int k = 0; k < 10; k++) begin
      gps_serial_receive <= k == 0 ? 1'b0 : k == 9 ? 1'b1 : b[k-1];
      repeat (BIT) @(posedge clk);
    end
  endtask

  // Sentence must end well inside the late limit of the unit
  task automatic rest(input string body, input bit bad);
    logic [7:0] cs;
    cs = 8'h00;
    while (cyc - t0 < WIDTH) @(posedge clk);
    pps_input <= 1'b0;
    for (int i = 1; i < body.len(); i++) cs ^= body[i];
    if (bad) cs = ~cs;
    if (body.len() > 0) begin
      body = $sformatf("%s*%02X\r\n", body, cs);
      for (int i = 0; i < body.len(); i++) send_byte(body[i]);
    end
    while (cyc - t0 < PERIOD) @(posedge clk);
  endtask
endmodule

/* File: test/testbench.sv */
// Self-checking bench for the PPS time synchronisation unit
`timescale 1ns/10ps
module testbench;
  import pts_pkg::*;
  localparam int PER = 10000;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic ce = 1'b1;
  logic [3:0] sel = 4'hf;
  logic [31:0] rdat;
  wire logic ack, irq, synced, locked, strobe, pps, rx;
  wire logic [31:0] dato, ns;
  wire logic [47:0] sec;
  wire logic [15:0] az_o;
  int fail_count = 0;
  int n_compared = 0;
  int cyc_n = 0;
  logic [7:0] rst_a [6] = '{REG_CTRL, REG_PHASE, REG_STATUS, REG_IRQ_STAT,
    REG_IRQ_MASK, 8'h40};
  string tg [7] = '{"RMC", "RMC", "RMC", "GGA", "RMC", "RMC", "RMC"};
  string vl [7] = '{"A", "A", "A", "A", "V", "A", "A"};
  string md [7] = '{"A", "N", "A", "A", "A", "A", "D"};

  initial forever #5 clk = ~clk;

  pts_time_sync #(.BIT_CYCLES(16), .PPS_MAX_CYCLES(3000),
    .PER_MIN_CYCLES(PER - 100), .PER_MAX_CYCLES(PER + 100),
    .RMC_LATE_CYCLES(8000)) u_pts_time_sync (
    .clk(clk), .srst(srst), .ce(ce), .gps_serial_receive(rx),
    .pps_input(pps), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dato),
    .wb_ack_o(ack), .ts_sec(sec), .ts_ns(ns), .ts_synced(synced),
    .pps_locked(locked), .rotor_lock_strobe(strobe),
    .rotor_lock_azimuth(az_o), .irq(irq));

  pts_gps_model #(.BIT(16), .WIDTH(1100), .PERIOD(PER)) u_pts_gps_model (
    .clk(clk), .pps_input(pps), .gps_serial_receive(rx));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic single cycle; waits for ack, never assumes a latency
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdat = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      close_out();
    end
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 95000) begin
      fail_count++;
      close_out();
    end
  end

  initial begin
    string body;
    logic [47:0] exp_sec, pend;
    logic pend_ok;
    int h, m, s;
    logic [15:0] az;
    logic [31:0] r;
    exp_sec = 48'h0;
    pend = 48'h0;
    pend_ok = 1'b0;
    void'($urandom(10041));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    #1;
    chk(sec, 0);
    chk(synced, 0);
    wb(1, 8'h40, 32'hffffffff);
    foreach (rst_a[i]) begin
      wb(0, rst_a[i], 0);
      chk(rdat, 0);
    end
    $display("reset test done");
    az = 16'($urandom % 36000);
    wb(1, REG_PHASE, {16'h0, az});
    wb(0, REG_PHASE, 0);
    chk(rdat, {16'h0, az});
    sel <= 4'h2;
    wb(1, REG_PHASE, 32'h34341234);
    sel <= 4'hf;
    az[15:8] = 8'h12;
    wb(0, REG_PHASE, 0);
    chk(rdat, {16'h0, az});
    wb(1, REG_CTRL, 32'h2);
    wb(1, REG_IRQ_MASK, 32'h1);
    for (int i = 0; i < 8; i++) begin
      u_pts_gps_model.pulse_start();
      @(posedge clk);
      #1;
      if (pend_ok) exp_sec = pend;
      chk(sec, exp_sec);
      if (pend_ok) chk(ns, 0);
      chk(synced, i >= 1);
      chk(strobe, i > 3);
      chk(az_o, az);
      chk(irq, i != 5);
      wb(0, REG_IRQ_STAT, 0);
      chk(rdat, {27'h0, i == 3, 1'b0, pend_ok, pend_ok, 1'b1});
      wb(1, REG_IRQ_STAT, 32'h1f);
      wb(0, REG_IRQ_STAT, 0);
      chk(rdat, 0);
      chk(irq, 0);
      wb(1, REG_IRQ_MASK, {31'h0, i != 4});
      pend_ok = 1'b0;
      body = "";
      if (i < 7) begin
        h = $urandom % 24;
        m = $urandom % 60;
        s = $urandom % 60;
        body = $sformatf("$GP%s,%02d%02d%02d,%s,%0d,,,,,,060103,,,%s",
          tg[i], h, m, s, vl[i], $urandom % 1000, md[i]);
        pend = 48'(12058 * 86400 + h * 3600 + m * 60 + s + 1);
        pend_ok = tg[i] == "RMC" && vl[i] == "A" && md[i] == "A" && i != 2;
      end
      u_pts_gps_model.rest(body, i == 2);
      $display("gps second %0d done", i);
    end
    r = $urandom & 32'h7fffffff;
    wb(1, REG_PTP_NS, 32'd999999980);
    wb(1, REG_PTP_SEC_LO, r);
    wb(1, REG_PTP_SEC_HI, 32'h0);
    wb(1, REG_CTRL, 32'h1);
    wb(1, REG_PTP_CMD, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    chk(ns, 0);
    chk(sec, {16'h0, r + 32'h1});
    $display("ptp test done");
    @(posedge clk);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(ns, NS_STEP);
    chk(sec, {16'h0, r + 32'h1});
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    #1;
    chk(ns, 2 * NS_STEP);
    $display("enable test done");
    close_out();
  end
endmodule
